//--- design/dsr_cfg.svh
// dsr_cfg.svh: register offsets, codes and timing figures of the slew/range block
// assumes: 20 MHz system clock, AXI4-Lite word registers
`ifndef DSR_CFG_SVH
`define DSR_CFG_SVH
`define DSR_OFF_CTRL   4'h0
`define DSR_OFF_CFG    4'h4
`define DSR_OFF_DATA   4'h8
`define DSR_OFF_STAT   4'hc
`define DSR_STAT_SLEW  1
`define DSR_RANGE_BAD  3'h4
`define DSR_RESP_OKAY  2'h0
`define DSR_RESP_ERR   2'h2
`define DSR_FRAC       4
`define DSR_CLK_HZ     20000000
`define DSR_SR_F0      258065
`define DSR_SR_F1      200000
`define DSR_SR_F2      153845
`define DSR_SR_F3      131145
`define DSR_SR_F4      115940
`define DSR_SR_F5      69565
`define DSR_SR_F6      37560
`define DSR_SR_F7      25805
`define DSR_SR_F8      20150
`define DSR_SR_F9      16030
`define DSR_SR_F10     10295
`define DSR_SR_F11     8280
`define DSR_SR_F12     6900
`define DSR_SR_F13     5530
`define DSR_SR_F14     4240
`define DSR_SR_F15     3300
`endif

//--- design/dsr_pkg.sv
// dsr_pkg: register field layouts and decoded span carrier
// assumes: included offsets come from dsr_cfg.svh
package dsr_pkg;
  typedef struct packed {
    logic [3:0] rate;
    logic [2:0] step;
    logic       slewEn;
    logic       overrange;
    logic [2:0] range;
  } dsr_ctrl_t;
  typedef struct packed {
    logic       clrSel;
    logic [1:0] currSpan;
    logic       dualEn;
  } dsr_cfg_t;
  typedef struct packed {
    logic       voltEn;
    logic [1:0] voltSpan;
    logic       overrange;
    logic       currEn;
    logic [1:0] currSpan;
  } dsr_span_t;
endpackage : dsr_pkg

//--- design/dsr_slew_range.sv
// dsr_slew_range: output code slew limiter and range decode behind AXI4-Lite
// assumes: single clock, inputs synchronous, analog stage consumes appliedCode/span
// Summary of operation
// - control bit 4 enables slew limiting
// - step amount bits 7:5, rate bits 11:8
// - disabled: new code applied at once
// - data readback returns applied code
// - 16-bit: step is 2^field LSBs
// - 12-bit: step 0.0625 to 8 LSBs
// - sixteen update rates 258065 to 3300 Hz
// - update rate independent of output range
// - clear input move is slewed too
// - status bit 1 set while slewing
// - normal mode range field decode
// - range code 100 rejected, old kept
// - range change clears data register
// - overrange widens voltage ranges 10%
// - dual mode: separate current range field
// - dual mode: 1xx disables voltage output
// - dual mode current field decode
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "dsr_cfg.svh"
module dsr_slew_range
  import dsr_pkg::*;
#(
  parameter int RES    = 16,
  parameter int CLK_HZ = `DSR_CLK_HZ
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [3:0]       awaddr,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  input  wire logic [3:0]       araddr,
  input  wire logic             arvalid,
  output logic                  arready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  input  wire logic             clearInput,
  output logic [RES-1:0]        appliedCode,
  output dsr_span_t             outSpan
);
  localparam int AW = RES + `DSR_FRAC;
  localparam int STEP_BASE = (RES == 16) ? `DSR_FRAC : 0;

  dsr_ctrl_t      ctrl_reg, ctrl_next;
  dsr_cfg_t       cfg_reg, cfg_next;
  logic [RES-1:0] data_reg, data_next;
  logic [AW-1:0]  appl_reg, appl_next;
  logic [23:0]    cnt_reg, cnt_next;
  logic           awFull_reg, awFull_next, wFull_reg, wFull_next;
  logic [3:0]     awAddr_reg, awAddr_next;
  logic [31:0]    wData_reg, wData_next, wMask;
  logic [3:0]     wStrb_reg, wStrb_next;
  logic           bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]     bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]    rdata_reg, rdata_next;
  dsr_span_t      span_reg, span_next;
  dsr_ctrl_t      ctrlW;
  logic [31:0]    ctrlMrg, cfgMrg;
  logic           doWr, tick, slewActive;
  logic [AW-1:0]  tgtFull, stepFrac, diff;

  function automatic logic [23:0] rateDiv(input logic [3:0] c);
    case (c)
      4'h0:    return 24'(CLK_HZ / `DSR_SR_F0);
      4'h1:    return 24'(CLK_HZ / `DSR_SR_F1);
      4'h2:    return 24'(CLK_HZ / `DSR_SR_F2);
      4'h3:    return 24'(CLK_HZ / `DSR_SR_F3);
      4'h4:    return 24'(CLK_HZ / `DSR_SR_F4);
      4'h5:    return 24'(CLK_HZ / `DSR_SR_F5);
      4'h6:    return 24'(CLK_HZ / `DSR_SR_F6);
      4'h7:    return 24'(CLK_HZ / `DSR_SR_F7);
      4'h8:    return 24'(CLK_HZ / `DSR_SR_F8);
      4'h9:    return 24'(CLK_HZ / `DSR_SR_F9);
      4'ha:    return 24'(CLK_HZ / `DSR_SR_F10);
      4'hb:    return 24'(CLK_HZ / `DSR_SR_F11);
      4'hc:    return 24'(CLK_HZ / `DSR_SR_F12);
      4'hd:    return 24'(CLK_HZ / `DSR_SR_F13);
      4'he:    return 24'(CLK_HZ / `DSR_SR_F14);
      default: return 24'(CLK_HZ / `DSR_SR_F15);
    endcase
  endfunction : rateDiv

  // voltage ranges clear to midscale when selected, current ranges to low end
  function automatic logic [RES-1:0] clrCode(input logic [2:0] rng, input logic sel);
    return (sel && !rng[2]) ? {1'b1, {(RES-1){1'b0}}} : '0;
  endfunction : clrCode

  assign awready = !awFull_reg && !bvalid_reg;
  assign wready  = !wFull_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;
  assign appliedCode = appl_reg[AW-1:`DSR_FRAC];
  assign outSpan = span_reg;

  // clear input overrides the target, so its move is slewed like any other
  assign tgtFull = {(clearInput ? clrCode(ctrl_reg.range, cfg_reg.clrSel) : data_reg),
                    {`DSR_FRAC{1'b0}}};
  assign stepFrac = AW'(1) << (STEP_BASE + int'(ctrl_reg.step));
  assign tick = (cnt_reg == 24'h0);
  assign slewActive = (appl_reg != tgtFull);
  assign wMask = {{8{wStrb_next[3]}}, {8{wStrb_next[2]}}, {8{wStrb_next[1]}},
                  {8{wStrb_next[0]}}};

  // bus and register file
  always_comb begin
    awFull_next = awFull_reg | (awvalid & awready);
    awAddr_next = (awvalid && awready) ? awaddr : awAddr_reg;
    wFull_next  = wFull_reg | (wvalid & wready);
    wData_next  = (wvalid && wready) ? wdata : wData_reg;
    wStrb_next  = (wvalid && wready) ? wstrb : wStrb_reg;
    bvalid_next = bvalid_reg && !bready;
    bresp_next  = bresp_reg;
    ctrl_next   = ctrl_reg;
    cfg_next    = cfg_reg;
    data_next   = data_reg;
    // byte lanes merge at bus width, then cut to the field set on purpose
    ctrlMrg = ({20'h0, ctrl_reg} & ~wMask) | (wData_next & wMask);
    cfgMrg  = ({28'h0, cfg_reg} & ~wMask) | (wData_next & wMask);
    ctrlW = dsr_ctrl_t'(ctrlMrg[$bits(dsr_ctrl_t)-1:0]);
    doWr = awFull_next && wFull_next && !bvalid_reg;
    if (doWr) begin
      awFull_next = 1'b0;
      wFull_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = `DSR_RESP_OKAY;
      case (awAddr_next)
        `DSR_OFF_CTRL: begin
          ctrl_next = ctrlW;
          if (ctrlW.range == `DSR_RANGE_BAD)
            ctrl_next.range = ctrl_reg.range;
          if (ctrl_next.range != ctrl_reg.range)
            data_next = clrCode(ctrl_next.range, cfg_reg.clrSel);
        end
        `DSR_OFF_CFG:  cfg_next = dsr_cfg_t'(cfgMrg[$bits(dsr_cfg_t)-1:0]);
        `DSR_OFF_DATA: data_next = RES'((({{(32-RES){1'b0}}, data_reg} & ~wMask)
                                         | (wData_next & wMask)));
        `DSR_OFF_STAT: ;
        default:       bresp_next = `DSR_RESP_ERR;
      endcase
    end
  end

  always_comb begin
    rvalid_next = rvalid_reg && !rready;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rresp_next  = `DSR_RESP_OKAY;
      rdata_next  = 32'h0;
      case (araddr)
        `DSR_OFF_CTRL: rdata_next = {20'h0, ctrl_reg};
        `DSR_OFF_CFG:  rdata_next = {28'h0, cfg_reg};
        `DSR_OFF_DATA: rdata_next = 32'(appliedCode);
        `DSR_OFF_STAT: rdata_next[`DSR_STAT_SLEW] = slewActive;
        default:       rresp_next = `DSR_RESP_ERR;
      endcase
    end
  end

  // slew engine; the divider never looks at the range
  always_comb begin
    cnt_next  = tick ? rateDiv(ctrl_reg.rate) - 24'h1 : cnt_reg - 24'h1;
    appl_next = appl_reg;
    diff      = '0;
    if (!ctrl_reg.slewEn) begin
      appl_next = tgtFull;
    end else if (tick) begin
      if (appl_reg < tgtFull) begin
        diff = tgtFull - appl_reg;
        appl_next = (diff > stepFrac) ? appl_reg + stepFrac : tgtFull;
      end else if (appl_reg > tgtFull) begin
        diff = appl_reg - tgtFull;
        appl_next = (diff > stepFrac) ? appl_reg - stepFrac : tgtFull;
      end
    end
  end

  // output span decode
  always_comb begin
    span_next = '0;
    if (cfg_reg.dualEn) begin
      span_next.voltEn   = !ctrl_reg.range[2];
      span_next.currEn   = (cfg_reg.currSpan != 2'h0);
      span_next.currSpan = cfg_reg.currSpan;
    end else begin
      span_next.voltEn   = !ctrl_reg.range[2];
      span_next.currEn   = ctrl_reg.range[2];
      span_next.currSpan = ctrl_reg.range[2] ? ctrl_reg.range[1:0] : 2'h0;
    end
    span_next.voltSpan  = span_next.voltEn ? ctrl_reg.range[1:0] : 2'h0;
    span_next.overrange = span_next.voltEn && ctrl_reg.overrange;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg   <= '0;
      cfg_reg    <= '0;
      data_reg   <= '0;
      appl_reg   <= '0;
      cnt_reg    <= 24'h0;
      awFull_reg <= 1'b0;
      awAddr_reg <= 4'h0;
      wFull_reg  <= 1'b0;
      wData_reg  <= 32'h0;
      wStrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg  <= 2'h0;
      rdata_reg  <= 32'h0;
      span_reg   <= '0;
    end else begin
      ctrl_reg   <= ctrl_next;
      cfg_reg    <= cfg_next;
      data_reg   <= data_next;
      appl_reg   <= appl_next;
      cnt_reg    <= cnt_next;
      awFull_reg <= awFull_next;
      awAddr_reg <= awAddr_next;
      wFull_reg  <= wFull_next;
      wData_reg  <= wData_next;
      wStrb_reg  <= wStrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
      span_reg   <= span_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_bypass_applies: assert property (!ctrl_reg.slewEn |=>
    appl_reg == $past(tgtFull)) else $error("bypass did not apply target");
  a_hold_between_ticks: assert property (ctrl_reg.slewEn && !tick |=>
    $stable(appl_reg)) else $error("applied code moved without tick");
  a_step_up_size: assert property (ctrl_reg.slewEn && tick && appl_reg < tgtFull |=>
    appl_reg == $past(appl_reg + ((tgtFull - appl_reg > stepFrac) ? stepFrac
      : tgtFull - appl_reg))) else $error("upward step wrong");
  a_no_overshoot: assert property (ctrl_reg.slewEn && tick && appl_reg > tgtFull
    |=> appl_reg >= $past(tgtFull)) else $error("downward step overshot");
  a_readback_applied: assert property (arvalid && arready && araddr == `DSR_OFF_DATA
    |=> rvalid && rdata == 32'($past(appliedCode))) else $error("readback not applied code");
  a_status_slew: assert property (rvalid_reg && $past(arvalid && arready
    && araddr == `DSR_OFF_STAT) |-> rdata[`DSR_STAT_SLEW] == $past(slewActive))
    else $error("status bit wrong");
  a_range_reject: assert property (doWr && awAddr_next == `DSR_OFF_CTRL
    && ctrlW.range == `DSR_RANGE_BAD |=> $stable(ctrl_reg.range))
    else $error("illegal range stored");
  a_range_clears: assert property (ctrl_next.range != ctrl_reg.range |=>
    data_reg == clrCode(ctrl_reg.range, cfg_reg.clrSel)) else $error("data not cleared");
  a_dual_voltoff: assert property (cfg_reg.dualEn && ctrl_reg.range[2] |=>
    !outSpan.voltEn) else $error("voltage left enabled");
  a_tick_reload: assert property (tick |=>
    cnt_reg == $past(rateDiv(ctrl_reg.rate)) - 24'h1) else $error("rate divider reload wrong");
  a_step_down_size: assert property (ctrl_reg.slewEn && tick && appl_reg > tgtFull |=>
    appl_reg == $past(appl_reg - ((appl_reg - tgtFull > stepFrac) ? stepFrac
      : appl_reg - tgtFull))) else $error("downward step wrong");
  a_clear_zero: assert property (clearInput && !cfg_reg.clrSel |-> tgtFull == '0)
    else $error("clear target not zero scale");

  // span checks; expected values come from the field codes, not the decode, except the overrange check, which tests against voltEn
  a_normal_span: assert property (!cfg_reg.dualEn |=>
    outSpan.voltEn == !$past(ctrl_reg.range[2])
    && outSpan.currEn == $past(ctrl_reg.range[2])) else $error("normal mode span wrong");
  a_ovr_volt_only: assert property (outSpan.overrange |-> outSpan.voltEn)
    else $error("overrange on current output");
  a_dual_current: assert property (cfg_reg.dualEn |=>
    outSpan.currSpan == $past(cfg_reg.currSpan)
    && outSpan.currEn == ($past(cfg_reg.currSpan) != 2'h0)) else $error("current span wrong");

  // responses must stand until the master takes them
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_read_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp)) else $error("read response dropped early");


  c_slew_done: cover property (ctrl_reg.slewEn && slewActive ##1 !slewActive);
  c_clear_slew: cover property (clearInput && ctrl_reg.slewEn && slewActive);
  c_range_bad: cover property (doWr && ctrlW.range == `DSR_RANGE_BAD);
  c_dual_mode: cover property (cfg_reg.dualEn && outSpan.currEn && outSpan.voltEn);
  c_rate_slow: cover property (ctrl_reg.slewEn && ctrl_reg.rate != 4'h0 && tick);
endmodule : dsr_slew_range

//--- tb/dsr_out_stage.sv
// dsr_out_stage: behavioural analog output stage fed by the slew/range block
// assumes: code and span are registered by the block on the same clock
`timescale 1ns/100ps
module dsr_out_stage
  import dsr_pkg::*;
#(
  parameter int RES = 16
) (
  input  wire logic           clock,
  input  wire logic [RES-1:0] code,
  input  dsr_span_t           span,
  output logic [RES-1:0]      voltCode,
  output logic [RES-1:0]      currCode
);
  // a disabled output floats rather than holding its last level
  always_ff @(posedge clock) begin
    voltCode <= span.voltEn ? code : 'z;
    currCode <= span.currEn ? code : 'z;
  end
endmodule : dsr_out_stage

//--- tb/tb.sv
// tb: register-level test of the slew limiter and range decode
// assumes: 20 MHz clock, AXI4-Lite master tasks, rate divisors scaled by CLK_HZ
`timescale 1ns/100ps
`include "dsr_cfg.svh"
module tb
  import dsr_pkg::*;
;
  logic clock, rstn, awvalid, wvalid, bready, arvalid, rready, clearInput;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp;
  logic [15:0] appliedCode;
  dsr_span_t outSpan;
  int fails, testsRun, cycles, n;
  // scaled clock: rate 0 ticks every 7 cycles, rate 1 every 10
  dsr_slew_range #(.RES(16), .CLK_HZ(2000000)) i_dut (
    .clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .clearInput(clearInput),
    .appliedCode(appliedCode), .outSpan(outSpan));
  dsr_out_stage #(.RES(16)) i_stage (.clock(clock), .code(appliedCode), .span(outSpan),
    .voltCode(), .currCode());
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  task closeOut;
    if (fails == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : closeOut
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      closeOut;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    testsRun++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", nm, e, s);
      fails++;
    end
  endtask : chk
  task axw(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, ra, rw, rb;
    ta = 0;
    tw = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge clock);
      ra = awvalid & awready;
      rw = wvalid & wready;
      @(posedge clock);
      if (ra) awvalid <= 0;
      if (rw) wvalid <= 0;
      ta |= ra;
      tw |= rw;
    end while (!(ta && tw));
    do begin
      @(negedge clock);
      rb = bvalid;
      @(posedge clock);
    end while (!rb);
    bready <= 0;
  endtask : axw
  task axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ra, rv;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge clock);
      ra = arready;
      @(posedge clock);
    end while (!ra);
    arvalid <= 0;
    do begin
      @(negedge clock);
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
    end while (!rv);
    rready <= 0;
  endtask : axr
  task waitChg(input logic [15:0] e);
    logic [15:0] old;
    old = appliedCode;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (appliedCode === old && n < 500);
    chk("appliedCode", {16'h0, e}, {16'h0, appliedCode});
    @(posedge clock);
  endtask : waitChg
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, clearInput} = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf;
    fails = 0; testsRun = 0; cycles = 0;
    repeat (16) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    chk("resetCode", 32'h0, {16'h0, appliedCode});
    axw(`DSR_OFF_CTRL, 32'hf0);
    axw(`DSR_OFF_DATA, 32'h12c);
    waitChg(16'h80);
    axr(`DSR_OFF_STAT, rd, rresp);
    chk("slewFlag", 32'h2, rd & 32'h2);
    axr(`DSR_OFF_DATA, rd, rresp);
    chk("dataMidSlew", 32'h80, rd);
    waitChg(16'h100);
    waitChg(16'h12c);
    chk("ratePeriod0", 32'd7, n);
    axr(`DSR_OFF_STAT, rd, rresp);
    chk("slewDone", 32'h0, rd & 32'h2);
    axw(`DSR_OFF_CTRL, 32'h1f0);
    clearInput <= 1;
    waitChg(16'hac);
    waitChg(16'h2c);
    chk("ratePeriod1", 32'd10, n);
    waitChg(16'h0);
    clearInput <= 0;
    axw(`DSR_OFF_CTRL, 32'h0);
    repeat (3) @(posedge clock);
    chk("slewOff", 32'h12c, {16'h0, appliedCode});
    axw(`DSR_OFF_DATA, 32'habcd);
    repeat (2) @(posedge clock);
    chk("direct", 32'habcd, {16'h0, appliedCode});
    for (int r = 0; r < 8; r++) begin
      if (r == 4) continue;
      axw(`DSR_OFF_DATA, 32'h55);
      axw(`DSR_OFF_CTRL, r);
      @(posedge clock);
      chk("voltEn", {31'h0, ~r[2]}, {31'h0, outSpan.voltEn});
      chk("currEn", {31'h0, r[2]}, {31'h0, outSpan.currEn});
      chk("span", r & 3, r[2] ? outSpan.currSpan : outSpan.voltSpan);
      axr(`DSR_OFF_DATA, rd, rresp);
      chk("clearOnRange", (r == 0) ? 32'h55 : 32'h0, rd);
    end
    axw(`DSR_OFF_CTRL, 32'h4);
    axr(`DSR_OFF_CTRL, rd, rresp);
    chk("badRange", 32'h7, rd & 32'h7);
    axw(`DSR_OFF_CFG, 32'h8);
    axw(`DSR_OFF_CTRL, 32'h3);
    axr(`DSR_OFF_DATA, rd, rresp);
    chk("midscale", 32'h8000, rd);
    axw(`DSR_OFF_CTRL, 32'h9);
    @(posedge clock);
    chk("ovrVolt", 32'h1, {31'h0, outSpan.overrange});
    axw(`DSR_OFF_CTRL, 32'hd);
    @(posedge clock);
    chk("ovrCurr", 32'h0, {31'h0, outSpan.overrange});
    for (int c = 0; c < 4; c++) begin
      axw(`DSR_OFF_CFG, (c << 1) | 1);
      @(posedge clock);
      chk("dualCurrEn", c != 0, {31'h0, outSpan.currEn});
      chk("dualCurrSpan", c, {30'h0, outSpan.currSpan});
      chk("dualVoltOff", 32'h0, {31'h0, outSpan.voltEn});
    end
    axw(`DSR_OFF_CTRL, 32'h2);
    @(posedge clock);
    chk("dualVolt", 32'h6, {29'h0, outSpan.voltEn, outSpan.voltSpan});
    chk("dualKeep", 32'h7, {29'h0, outSpan.currEn, outSpan.currSpan});
    axr(4'h2, rd, rresp);
    chk("unmapped", `DSR_RESP_ERR, rresp);
    closeOut;
  end
endmodule : tb
